// ===== pkg/rcbs_consts.svh
/*
  Constants for the rotate-through-carry and single-bit-set datapath.
  Assumes the core keeps carry in the top bit of the program status word.
*/
`ifndef RCBS_CONSTS_SVH
`define RCBS_CONSTS_SVH

// ------------------------------------------------------------
// opcode encodings
// ------------------------------------------------------------
`define RCBS_OPC_ROTATE      8'h13
`define RCBS_OPC_SET_CARRY   8'hd3
`define RCBS_OPC_SET_DIRECT  8'hd2

// ------------------------------------------------------------
// field positions, reset values and execute length
// ------------------------------------------------------------
`define RCBS_CARRY_POS       7
`define RCBS_ACC_MSB         7
`define RCBS_ACC_RST         8'h00
`define RCBS_PSW_RST         8'h00
`define RCBS_ADDR_RST        8'h00
`define RCBS_EXEC_CYCLES     1

`endif

// ===== pkg/rcbs_pkg.sv
/*
  Types for the rotate-through-carry and single-bit-set datapath.
  Assumes nothing beyond the constants header.
*/
package rcbs_pkg;

  typedef enum logic [1:0] {
    OP_NONE       = 2'b00,
    OP_ROTATE     = 2'b01,
    OP_SET_CARRY  = 2'b11,
    OP_SET_DIRECT = 2'b10
  } op_kind_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_DONE = 2'b11
  } exec_state_e;

endpackage : rcbs_pkg

// ===== design/op_classify.sv
/*
  Opcode classifier for the rotate and set-bit datapath.
  Assumes the opcode byte is stable while it is classified.
*/
`timescale 1ns/1ps
`include "rcbs_consts.svh"

module op_classify (
  input  wire logic [7:0]       opcode_i,
  output rcbs_pkg::op_kind_e    kind_o
);

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  function automatic rcbs_pkg::op_kind_e classify(input logic [7:0] code);
    rcbs_pkg::op_kind_e k;
    k = rcbs_pkg::OP_NONE;
    case (code)
      `RCBS_OPC_ROTATE:     k = rcbs_pkg::OP_ROTATE;
      `RCBS_OPC_SET_CARRY:  k = rcbs_pkg::OP_SET_CARRY;
      `RCBS_OPC_SET_DIRECT: k = rcbs_pkg::OP_SET_DIRECT;
      default:              k = rcbs_pkg::OP_NONE;
    endcase
    return k;
  endfunction : classify

  assign kind_o = classify(opcode_i);

endmodule : op_classify

// ===== design/rotate_carry_and_bit_set.sv
/*
  Execution datapath for rotate-right-through-carry and set-single-bit.
  Assumes the decoder presents one request at a time with ready_o high,
  and that the accumulator, status word and bit storage take the write
  strobes in the cycle they are shown.
*/
`timescale 1ns/1ps
`include "rcbs_consts.svh"

module rotate_carry_and_bit_set (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       op_valid_i,
  input  wire logic [7:0] opcode_i,
  input  wire logic [7:0] bit_addr_i,
  input  wire logic [7:0] acc_i,
  input  wire logic [7:0] psw_i,
  output logic            ready_o,
  output logic [7:0]      acc_o,
  output logic            acc_we_o,
  output logic [7:0]      psw_o,
  output logic            psw_we_o,
  output logic [7:0]      bit_addr_o,
  output logic            bit_data_o,
  output logic            bit_we_o,
  output logic            done_o,
  output logic            unknown_op_o
);

  // ------------------------------------------------------------
  // request capture
  // ------------------------------------------------------------
  rcbs_pkg::exec_state_e state_reg;
  rcbs_pkg::exec_state_e state_next;
  rcbs_pkg::op_kind_e    in_kind;
  rcbs_pkg::op_kind_e    kind_reg;
  logic [7:0]            acc_cap_reg;
  logic [7:0]            psw_cap_reg;
  logic [7:0]            addr_cap_reg;
  logic                  take;

  op_classify u_classify (
    .opcode_i (opcode_i),
    .kind_o   (in_kind)
  );

  // a new request is only taken in idle; the decoder must hold it otherwise
  assign take = op_valid_i && ready_o;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      kind_reg     <= rcbs_pkg::OP_NONE;
      acc_cap_reg  <= `RCBS_ACC_RST;
      psw_cap_reg  <= `RCBS_PSW_RST;
      addr_cap_reg <= `RCBS_ADDR_RST;
    end else if (take) begin
      kind_reg     <= in_kind;
      acc_cap_reg  <= acc_i;
      psw_cap_reg  <= psw_i;
      addr_cap_reg <= bit_addr_i;
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rcbs_pkg::ST_IDLE: if (take) state_next = rcbs_pkg::ST_EXEC;
      rcbs_pkg::ST_EXEC: state_next = rcbs_pkg::ST_DONE;
      rcbs_pkg::ST_DONE: state_next = rcbs_pkg::ST_IDLE;
      default:           state_next = rcbs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= rcbs_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------
  // rotate path
  // ------------------------------------------------------------
  logic [7:0] rot_acc;
  logic [7:0] rot_psw;
  logic       old_carry;

  assign old_carry = psw_cap_reg[`RCBS_CARRY_POS];

  // nine-bit ring: carry sits above bit 7 and below bit 0
  genvar gi;
  generate
    for (gi = 0; gi < `RCBS_ACC_MSB; gi++) begin : g_shift
      assign rot_acc[gi] = acc_cap_reg[gi+1];
    end
  endgenerate
  assign rot_acc[`RCBS_ACC_MSB] = old_carry;

  // only the carry position is replaced; all other flags pass through
  assign rot_psw = (psw_cap_reg & ~(8'h01 << `RCBS_CARRY_POS))
                 | ({7'h00, acc_cap_reg[0]} << `RCBS_CARRY_POS);

  // ------------------------------------------------------------
  // set-bit path
  // ------------------------------------------------------------
  logic [7:0] set_psw;
  assign set_psw = psw_cap_reg | (8'h01 << `RCBS_CARRY_POS);

  // ------------------------------------------------------------
  // result select
  // ------------------------------------------------------------
  logic       exec;
  logic       is_rot;
  logic       is_setc;
  logic       is_setd;
  logic       is_none;
  logic [7:0] acc_next;
  logic       acc_we_next;
  logic [7:0] psw_next;
  logic       psw_we_next;
  logic [7:0] addr_next;
  logic       bit_data_next;
  logic       bit_we_next;
  logic       done_next;
  logic       unknown_next;
  logic       ready_next;

  assign exec    = (state_reg == rcbs_pkg::ST_EXEC);
  assign is_rot  = exec && (kind_reg == rcbs_pkg::OP_ROTATE);
  assign is_setc = exec && (kind_reg == rcbs_pkg::OP_SET_CARRY);
  assign is_setd = exec && (kind_reg == rcbs_pkg::OP_SET_DIRECT);
  assign is_none = exec && (kind_reg == rcbs_pkg::OP_NONE);

  assign acc_next      = is_rot ? rot_acc : acc_o;
  assign acc_we_next   = is_rot;
  assign psw_next      = is_rot ? rot_psw : (is_setc ? set_psw : psw_o);
  assign psw_we_next   = is_rot || is_setc;
  // direct target goes to bit storage, which drives port latches itself
  assign addr_next     = is_setd ? addr_cap_reg : bit_addr_o;
  assign bit_data_next = is_setd || bit_data_o;
  assign bit_we_next   = is_setd;
  assign done_next     = exec;
  assign unknown_next  = is_none;
  assign ready_next    = (state_next == rcbs_pkg::ST_IDLE);

  // ------------------------------------------------------------
  // output registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      acc_o        <= `RCBS_ACC_RST;
      acc_we_o     <= 1'b0;
      psw_o        <= `RCBS_PSW_RST;
      psw_we_o     <= 1'b0;
      bit_addr_o   <= `RCBS_ADDR_RST;
      bit_data_o   <= 1'b0;
      bit_we_o     <= 1'b0;
      done_o       <= 1'b0;
      unknown_op_o <= 1'b0;
      ready_o      <= 1'b1;
    end else begin
      acc_o        <= acc_next;
      acc_we_o     <= acc_we_next;
      psw_o        <= psw_next;
      psw_we_o     <= psw_we_next;
      bit_addr_o   <= addr_next;
      bit_data_o   <= bit_data_next;
      bit_we_o     <= bit_we_next;
      done_o       <= done_next;
      unknown_op_o <= unknown_next;
      ready_o      <= ready_next;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // set-bit never clears the data line once driven; it stays one until reset
  rotate_ring_a: assert property (@(posedge clk_i) disable iff (srst_i)
    take && in_kind == rcbs_pkg::OP_ROTATE |-> ##2
      acc_we_o && acc_o[6:0] == $past(acc_i[7:1], 2))
    else $error("rotate did not shift accumulator right");

  carry_in_a: assert property (@(posedge clk_i) disable iff (srst_i)
    take && in_kind == rcbs_pkg::OP_ROTATE |-> ##2
      acc_o[7] == $past(psw_i[`RCBS_CARRY_POS], 2)
      && psw_o[`RCBS_CARRY_POS] == $past(acc_i[0], 2))
    else $error("carry and bit exchange wrong on rotate");

  rot_flags_a: assert property (@(posedge clk_i) disable iff (srst_i)
    take && in_kind == rcbs_pkg::OP_ROTATE |-> ##2
      psw_we_o && ((psw_o ^ $past(psw_i, 2)) & ~(8'h01 << `RCBS_CARRY_POS)) == 8'h00)
    else $error("rotate altered a non-carry flag");

  set_carry_a: assert property (@(posedge clk_i) disable iff (srst_i)
    take && in_kind == rcbs_pkg::OP_SET_CARRY |-> ##2
      psw_we_o && psw_o[`RCBS_CARRY_POS] && !acc_we_o && !bit_we_o)
    else $error("carry set-bit failed");

  set_direct_a: assert property (@(posedge clk_i) disable iff (srst_i)
    take && in_kind == rcbs_pkg::OP_SET_DIRECT |-> ##2
      bit_we_o && bit_data_o && bit_addr_o == $past(bit_addr_i, 2) && !psw_we_o)
    else $error("direct set-bit write wrong");

  set_flags_a: assert property (@(posedge clk_i) disable iff (srst_i)
    take && in_kind == rcbs_pkg::OP_SET_CARRY |-> ##2
      ((psw_o ^ $past(psw_i, 2)) & ~(8'h01 << `RCBS_CARRY_POS)) == 8'h00)
    else $error("set-bit altered another flag");

  decode_known_a: assert property (@(posedge clk_i) disable iff (srst_i)
    take && opcode_i != `RCBS_OPC_ROTATE && opcode_i != `RCBS_OPC_SET_CARRY
      && opcode_i != `RCBS_OPC_SET_DIRECT |-> ##2
      unknown_op_o && !acc_we_o && !psw_we_o && !bit_we_o)
    else $error("unknown opcode caused a write");

  busy_window_a: assert property (@(posedge clk_i) disable iff (srst_i)
    take |=> !ready_o ##1 (!ready_o && done_o) ##1 ready_o)
    else $error("ready sequence wrong");

  cover_rotate_c: cover property (@(posedge clk_i) disable iff (srst_i)
    take && in_kind == rcbs_pkg::OP_ROTATE ##2 acc_we_o);
  cover_setc_c: cover property (@(posedge clk_i) disable iff (srst_i)
    take && in_kind == rcbs_pkg::OP_SET_CARRY ##2 psw_we_o);
  cover_setd_c: cover property (@(posedge clk_i) disable iff (srst_i)
    take && in_kind == rcbs_pkg::OP_SET_DIRECT ##2 bit_we_o);
  cover_b2b_c: cover property (@(posedge clk_i) disable iff (srst_i)
    take ##3 take);

endmodule : rotate_carry_and_bit_set

// ===== tb/testbench.sv
/*
  Self-checking bench for the rotate-through-carry and single-bit-set datapath.
  Assumes the design takes a request when op_valid_i and ready_o are high at an edge,
  answers two cycles later and is idle again in the cycle after that.
*/
`timescale 1ns/1ps
`include "rcbs_consts.svh"

module testbench;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic       clk_i;
  logic       srst_i;
  logic       op_valid_i;
  logic [7:0] opcode_i;
  logic [7:0] bit_addr_i;
  logic [7:0] acc_i;
  logic [7:0] psw_i;
  logic       ready_o;
  logic [7:0] acc_o;
  logic       acc_we_o;
  logic [7:0] psw_o;
  logic       psw_we_o;
  logic [7:0] bit_addr_o;
  logic       bit_data_o;
  logic       bit_we_o;
  logic       done_o;
  logic       unknown_op_o;
  logic [7:0] acc_m;
  logic [7:0] psw_m;
  logic [7:0] addr_m;
  logic       bit_m;
  int         fail_count;
  int         compares;
  integer     seed;

  rotate_carry_and_bit_set i_dut (
    .clk_i(clk_i), .srst_i(srst_i), .op_valid_i(op_valid_i), .opcode_i(opcode_i),
    .bit_addr_i(bit_addr_i), .acc_i(acc_i), .psw_i(psw_i), .ready_o(ready_o),
    .acc_o(acc_o), .acc_we_o(acc_we_o), .psw_o(psw_o), .psw_we_o(psw_we_o),
    .bit_addr_o(bit_addr_o), .bit_data_o(bit_data_o), .bit_we_o(bit_we_o),
    .done_o(done_o), .unknown_op_o(unknown_op_o)
  );

  initial clk_i = 1'b0;
  always #4 clk_i = ~clk_i;

  // ------------------------------------------------------------
  // checking helpers
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] expected);
    compares = compares + 1;
    if (seen !== expected) begin
      fail_count = fail_count + 1;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask : check

  task automatic results;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  // strobes packed as acc_we, psw_we, bit_we, done, unknown
  function automatic logic [7:0] exp_strobes(input logic [7:0] opc);
    case (opc)
      `RCBS_OPC_ROTATE:     exp_strobes = 8'h1a;
      `RCBS_OPC_SET_CARRY:  exp_strobes = 8'h0a;
      `RCBS_OPC_SET_DIRECT: exp_strobes = 8'h06;
      default:              exp_strobes = 8'h03;
    endcase
  endfunction : exp_strobes

  function automatic logic [7:0] strobes_seen();
    strobes_seen = {3'h0, acc_we_o, psw_we_o, bit_we_o, done_o, unknown_op_o};
  endfunction : strobes_seen

  // idle: ready high, no strobes, data outputs hold the last results
  task automatic check_idle;
    check({7'h0, ready_o}, 8'h01);
    check(strobes_seen(), 8'h00);
    check(acc_o, acc_m);
    check(psw_o, psw_m);
    check(bit_addr_o, addr_m);
    check({7'h0, bit_data_o}, {7'h0, bit_m});
  endtask : check_idle

  // ------------------------------------------------------------
  // one request; inputs scrambled after the take to prove sampling
  // ------------------------------------------------------------
  task automatic run_op(input logic [7:0] opc, input logic [7:0] addr,
                        input logic [7:0] acc, input logic [7:0] psw);
    @(posedge clk_i);
    op_valid_i <= 1'b1;
    opcode_i   <= opc;
    bit_addr_i <= addr;
    acc_i      <= acc;
    psw_i      <= psw;
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    acc_i      <= 8'($random(seed));
    psw_i      <= 8'($random(seed));
    bit_addr_i <= 8'($random(seed));
    case (opc)
      `RCBS_OPC_ROTATE: begin
        acc_m = {psw[7], acc[7:1]};
        psw_m = {acc[0], psw[6:0]};
      end
      `RCBS_OPC_SET_CARRY:  psw_m = psw | 8'h80;
      `RCBS_OPC_SET_DIRECT: begin
        addr_m = addr;
        bit_m  = 1'b1;
      end
      default: ;
    endcase
    // strobes stand only between the first and second edge after the take
    #1 check({7'h0, ready_o}, 8'h00);
    @(posedge clk_i);
    #1 check({7'h0, ready_o}, 8'h00);
    check(strobes_seen(), exp_strobes(opc));
    check(acc_o, acc_m);
    check(psw_o, psw_m);
    check(bit_addr_o, addr_m);
    check({7'h0, bit_data_o}, {7'h0, bit_m});
    @(posedge clk_i);
    #1 check_idle();
  endtask : run_op

  task automatic clear_model;
    acc_m  = 8'h00;
    psw_m  = 8'h00;
    addr_m = 8'h00;
    bit_m  = 1'b0;
  endtask : clear_model

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] opc;
    seed = 25677;
    fail_count = 0;
    compares = 0;
    srst_i = 1'b1;
    op_valid_i = 1'b0;
    opcode_i = 8'h00;
    bit_addr_i = 8'h00;
    acc_i = 8'h00;
    psw_i = 8'h00;
    clear_model();
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    #1 check_idle();
    run_op(`RCBS_OPC_ROTATE, 8'h00, 8'hc5, 8'h00);
    run_op(`RCBS_OPC_ROTATE, 8'h00, 8'hff, 8'hff);
    run_op(`RCBS_OPC_ROTATE, 8'h00, 8'h01, 8'h7f);
    run_op(`RCBS_OPC_ROTATE, 8'h00, 8'h80, 8'h80);
    run_op(`RCBS_OPC_SET_CARRY, 8'h00, 8'h55, 8'h80);
    run_op(`RCBS_OPC_SET_CARRY, 8'h00, 8'h00, 8'h7f);
    run_op(`RCBS_OPC_SET_DIRECT, 8'h90, 8'h00, 8'h00);
    run_op(`RCBS_OPC_SET_DIRECT, 8'hff, 8'haa, 8'h00);
    run_op(8'h03, 8'h11, 8'hc5, 8'h80);
    // mid-run reset must clear held results
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    clear_model();
    #1 check_idle();
    for (int i = 0; i < 60; i++) begin
      case ($random(seed) & 3)
        0:       opc = `RCBS_OPC_ROTATE;
        1:       opc = `RCBS_OPC_SET_CARRY;
        2:       opc = `RCBS_OPC_SET_DIRECT;
        default: opc = 8'($random(seed));
      endcase
      run_op(opc, 8'($random(seed)), 8'($random(seed)), 8'($random(seed)));
    end
    results();
  end

  // hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (3000) @(posedge clk_i);
    fail_count = fail_count + 1;
    results();
  end
endmodule : testbench
